// ### mhss_dev.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// transmit queue
// ------------------------------------------------------------------
module mhss_fifo #(
  parameter int W = mhss_pkg::BYTE_W,
  parameter int D = mhss_pkg::TXQ_DEPTH
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
    logic                rdy;
    logic                vld;
  } mhss_fifo_st_t;

  mhss_fifo_st_t q_ff;
  mhss_fifo_st_t nxt_q;
  logic          push;
  logic          pop;

  always_comb begin
    nxt_q = q_ff;
    push  = i_valid & q_ff.rdy;
    pop   = i_ready & q_ff.vld;
    if (push) begin
      nxt_q.mem[q_ff.wp] = i_data;
      nxt_q.wp           = q_ff.wp + 1'h1;
    end
    if (pop) begin
      nxt_q.rp = q_ff.rp + 1'h1;
    end
    case ({push, pop})
      2'h2:    nxt_q.cnt = q_ff.cnt + 1'h1;
      2'h1:    nxt_q.cnt = q_ff.cnt - 1'h1;
      default: nxt_q.cnt = q_ff.cnt;
    endcase
    // flags registered so the top sees ready straight from a flop
    nxt_q.rdy = nxt_q.cnt != (PW+1)'(D);
    nxt_q.vld = nxt_q.cnt != '0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_ready = q_ff.rdy;
  assign o_valid = q_ff.vld;
  assign o_data  = q_ff.mem[q_ff.rp];
endmodule

// ------------------------------------------------------------------
// slave end of the host link
// ------------------------------------------------------------------
module mhss_dev #(
  parameter int DW        = mhss_pkg::BYTE_W,
  parameter int BUF       = mhss_pkg::BUF_BYTES,
  parameter int QD        = mhss_pkg::TXQ_DEPTH,
  parameter int DC_PERIOD = mhss_pkg::DC_PERIOD_CYC,
  parameter int DC_B_OFS  = mhss_pkg::DC_B_OFS_CYC
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_cpol,
  input  wire logic          i_cpha,
  input  wire logic [DW-1:0] i_tx_data,
  input  wire logic          i_tx_valid,
  output logic               o_tx_ready,
  output logic [DW-1:0]      o_rx_data,
  output logic               o_rx_valid,
  input  wire logic          i_rx_ready,
  output logic               o_rx_overrun,
  output logic               o_selected,
  input  wire logic          i_dc_enable,
  output logic               o_dist_clock_pulse_a,
  output logic               o_dist_clock_pulse_b,
  mhss_if.dev                ifc
);
  localparam int AW = $clog2(BUF);
  localparam int BW = $clog2(DW);
  localparam int CW = $clog2(DC_PERIOD);

  if (DW != 8 || BUF < 2 || (BUF & (BUF - 1)) != 0 || DC_PERIOD < 2
      || DC_B_OFS >= DC_PERIOD) begin : g_chk
    $error("byte width must be 8, buffer a power of two, pulse offset inside period");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  sclk_m;
    logic                  sclk_s;
    logic                  sclk_d;
    logic                  sel_m;
    logic                  sel_s;
    logic                  sel_d;
    logic                  mosi_m;
    logic                  mosi_s;
    logic [BW-1:0]         rx_cnt;
    logic [BW-1:0]         tx_cnt;
    logic [DW-1:0]         rx_sh;
    logic [DW-1:0]         tx_sh;
    logic                  tx_q;
    logic                  miso;
    logic                  miso_oe;
    logic [BUF-1:0][DW-1:0] mem;
    logic [AW:0]           wr;
    logic [AW:0]           rd;
    logic [DW-1:0]         rx_data;
    logic                  rx_valid;
    logic                  ovf;
    logic [CW-1:0]         dc_cnt;
    logic                  dc_a;
    logic                  dc_b;
  } mhss_dev_st_t;

  mhss_dev_st_t  q_ff;
  mhss_dev_st_t  nxt_q;
  logic          chg;
  logic          lead;
  logic          trail;
  logic          sel_rise;
  logic          drive;
  logic          sample;
  logic          buf_full;
  logic          buf_empty;
  logic          pop;
  logic          q_vld;
  logic [DW-1:0] q_dat;
  logic [DW-1:0] ld_byte;

  // call traffic waits here so the link never stalls on the user side
  mhss_fifo #(
    .W (DW),
    .D (QD)
  ) u_txq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_valid   (i_tx_valid),
    .o_ready   (o_tx_ready),
    .i_data    (i_tx_data),
    .o_valid   (q_vld),
    .i_ready   (pop),
    .o_data    (q_dat)
  );

  // ----------------------------------------------------------------
  // edge decode on synchronised link pins
  // ----------------------------------------------------------------
  assign chg       = q_ff.sclk_s ^ q_ff.sclk_d;
  assign lead      = chg & (q_ff.sclk_s ^ i_cpol);
  assign trail     = chg & ~(q_ff.sclk_s ^ i_cpol);
  assign sel_rise  = q_ff.sel_s & ~q_ff.sel_d;
  assign drive     = q_ff.sel_s & (i_cpha ? lead : (trail | sel_rise));
  assign sample    = q_ff.sel_s & (i_cpha ? trail : lead);
  assign buf_empty = q_ff.wr == q_ff.rd;
  assign buf_full  = (q_ff.wr[AW-1:0] == q_ff.rd[AW-1:0]) && (q_ff.wr[AW] != q_ff.rd[AW]);

  always_comb begin
    nxt_q   = q_ff;
    pop     = 1'h0;
    ld_byte = q_vld ? q_dat : mhss_pkg::FILL_BYTE;
    // clock taken only as a sampled level, no relation assumed
    nxt_q.sclk_m  = ifc.sclk;
    nxt_q.sclk_s  = q_ff.sclk_m;
    nxt_q.sclk_d  = q_ff.sclk_s;
    nxt_q.sel_m   = ~ifc.ss_n;
    nxt_q.sel_s   = q_ff.sel_m;
    nxt_q.sel_d   = q_ff.sel_s;
    nxt_q.mosi_m  = ifc.mosi;
    nxt_q.mosi_s  = q_ff.mosi_m;
    nxt_q.ovf     = 1'h0;
    nxt_q.miso_oe = q_ff.sel_s;
    if (!q_ff.sel_s) begin
      // partial byte at frame end is dropped
      nxt_q.rx_cnt = '0;
      nxt_q.tx_cnt = '0;
      nxt_q.tx_q   = 1'h0;
    end
    // ----------------------------------------------------------------
    // transmit: only clocked out against the master's request
    // ----------------------------------------------------------------
    if (drive) begin
      if (q_ff.tx_cnt == '0) begin
        // head only peeked; popped on the first sample edge of the byte
        nxt_q.miso  = ld_byte[DW-1];
        nxt_q.tx_sh = {ld_byte[DW-2:0], 1'h0};
        nxt_q.tx_q  = q_vld;
      end else begin
        nxt_q.miso  = q_ff.tx_sh[DW-1];
        nxt_q.tx_sh = {q_ff.tx_sh[DW-2:0], 1'h0};
      end
      nxt_q.tx_cnt = q_ff.tx_cnt + 1'h1;
    end
    // ----------------------------------------------------------------
    // receive into the transfer buffer
    // ----------------------------------------------------------------
    if (sample) begin
      nxt_q.rx_sh  = {q_ff.rx_sh[DW-2:0], q_ff.mosi_s};
      nxt_q.rx_cnt = q_ff.rx_cnt + 1'h1;
      if (q_ff.rx_cnt == '0) begin
        pop        = q_ff.tx_q;
        nxt_q.tx_q = 1'h0;
      end
      if (q_ff.rx_cnt == BW'(DW - 1)) begin
        if (!buf_full) begin
          nxt_q.mem[q_ff.wr[AW-1:0]] = {q_ff.rx_sh[DW-2:0], q_ff.mosi_s};
          nxt_q.wr                   = q_ff.wr + 1'h1;
        end else begin
          nxt_q.ovf = 1'h1;
        end
      end
    end
    if (!q_ff.rx_valid || i_rx_ready) begin
      if (!buf_empty) begin
        nxt_q.rx_data  = q_ff.mem[q_ff.rd[AW-1:0]];
        nxt_q.rx_valid = 1'h1;
        nxt_q.rd       = q_ff.rd + 1'h1;
      end else begin
        nxt_q.rx_valid = 1'h0;
      end
    end
    // ----------------------------------------------------------------
    // distributed clock pulses
    // ----------------------------------------------------------------
    if (i_dc_enable) begin
      nxt_q.dc_cnt = (q_ff.dc_cnt == CW'(DC_PERIOD - 1)) ? '0 : q_ff.dc_cnt + 1'h1;
      nxt_q.dc_a   = q_ff.dc_cnt == '0;
      nxt_q.dc_b   = q_ff.dc_cnt == CW'(DC_B_OFS);
    end else begin
      nxt_q.dc_cnt = '0;
      nxt_q.dc_a   = 1'h0;
      nxt_q.dc_b   = 1'h0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ifc.miso_o           = q_ff.miso;
  assign ifc.miso_oe          = q_ff.miso_oe;
  assign o_rx_data            = q_ff.rx_data;
  assign o_rx_valid           = q_ff.rx_valid;
  assign o_rx_overrun         = q_ff.ovf;
  assign o_selected           = q_ff.sel_s;
  assign o_dist_clock_pulse_a = q_ff.dc_a;
  assign o_dist_clock_pulse_b = q_ff.dc_b;
endmodule

// ### mhss_hst.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// master end of the host link
// ------------------------------------------------------------------
module mhss_hst #(
  parameter int DW   = mhss_pkg::BYTE_W,
  parameter int HALF = mhss_pkg::SCLK_HALF_CYC
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_cpol,
  input  wire logic          i_cpha,
  input  wire logic [DW-1:0] i_tx_data,
  input  wire logic          i_tx_valid,
  output logic               o_tx_ready,
  output logic [DW-1:0]      o_rx_data,
  output logic               o_rx_valid,
  mhss_if.hst                ifc
);
  localparam int DVW = $clog2(HALF + 1);
  localparam int EW  = $clog2(DW) + 1;

  if (DW != 8 || HALF < mhss_pkg::SCLK_HALF_MIN_CYC
      || HALF < mhss_pkg::SYNC_HALF_MIN_CYC) begin : g_chk
    $error("half period too short for link timing or byte width not 8");
  end

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_XFER, H_HOLD} mhss_hst_state_t;

  typedef struct packed {
    mhss_hst_state_t st;
    logic [DVW-1:0]  div;
    logic [EW-1:0]   edg;
    logic            sclk;
    logic            ss_n;
    logic            mosi;
    logic [DW-1:0]   tx_sh;
    logic [DW-1:0]   rx_sh;
    logic            miso_m;
    logic            miso_s;
    logic [DW-1:0]   rx_data;
    logic            rx_valid;
    logic            tx_ready;
  } mhss_hst_st_t;

  localparam mhss_hst_st_t HST_RST = '{st: H_IDLE, ss_n: 1'h1, default: '0};

  mhss_hst_st_t q_ff;
  mhss_hst_st_t nxt_q;
  logic         tick;

  // half-period enable from the system clock
  assign tick = q_ff.div == DVW'(HALF - 1);

  always_comb begin
    nxt_q          = q_ff;
    nxt_q.rx_valid = 1'h0;
    nxt_q.miso_m   = ifc.miso;
    nxt_q.miso_s   = q_ff.miso_m;
    nxt_q.div      = tick ? '0 : q_ff.div + 1'h1;
    case (q_ff.st)
      H_IDLE, H_HOLD: begin
        nxt_q.tx_ready = 1'h1;
        if (i_tx_valid && q_ff.tx_ready) begin
          // select held low across back-to-back bytes
          nxt_q.tx_ready = 1'h0;
          nxt_q.ss_n     = 1'h0;
          nxt_q.st       = H_SETUP;
          nxt_q.div      = '0;
          nxt_q.edg      = '0;
          nxt_q.tx_sh    = i_tx_data;
          if (!i_cpha) begin
            nxt_q.mosi  = i_tx_data[DW-1];
            nxt_q.tx_sh = {i_tx_data[DW-2:0], 1'h0};
          end
        end else if (q_ff.st == H_IDLE || tick) begin
          nxt_q.st   = H_IDLE;
          nxt_q.ss_n = 1'h1;
          nxt_q.sclk = i_cpol;
        end
      end
      H_SETUP: begin
        if (tick) begin
          nxt_q.st = H_XFER;
        end
      end
      H_XFER: begin
        if (tick) begin
          nxt_q.sclk = ~q_ff.sclk;
          nxt_q.edg  = q_ff.edg + 1'h1;
          if (q_ff.edg[0] ^ ~i_cpha) begin
            nxt_q.rx_sh = {q_ff.rx_sh[DW-2:0], q_ff.miso_s};
          end else begin
            nxt_q.mosi  = q_ff.tx_sh[DW-1];
            nxt_q.tx_sh = {q_ff.tx_sh[DW-2:0], 1'h0};
          end
          if (q_ff.edg == EW'(2 * DW - 1)) begin
            nxt_q.st       = H_HOLD;
            nxt_q.rx_data  = nxt_q.rx_sh;
            nxt_q.rx_valid = 1'h1;
            nxt_q.tx_ready = 1'h1;
          end
        end
      end
      default: begin
        nxt_q = HST_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= HST_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ifc.sclk   = q_ff.sclk;
  assign ifc.ss_n   = q_ff.ss_n;
  assign ifc.mosi   = q_ff.mosi;
  assign o_tx_ready = q_ff.tx_ready;
  assign o_rx_data  = q_ff.rx_data;
  assign o_rx_valid = q_ff.rx_valid;
endmodule

// ### mhss_if.sv
`timescale 1ns/1ns
interface mhss_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // released line reads as pulled up
  assign miso = miso_oe ? miso_o : 1'h1;

  modport dev (input sclk, ss_n, mosi, output miso_o, miso_oe);
  modport hst (output sclk, ss_n, mosi, input miso);
endinterface

// ### mhss_pkg.sv
// Notes on behaviour
// - one 8-bit byte per transfer, MSB first
// - 128-byte buffer holds queued host traffic
// - slave acts only while select is low
// - reset returns whole port and buffer
// - master makes clock, slave only follows it
// - MOSI into slave, MISO driven by slave
// - master picks clock polarity and phase
// - serial clock treated asynchronous, synchronised inside
// - slave answers only requests, never volunteers
// - process and call data share decoupled path
// - sync pulses only while distributed clock active
package mhss_pkg;
  // ----------------------------------------------------------------
  // framing and buffers
  // ----------------------------------------------------------------
  localparam int         BYTE_W    = 8;
  localparam int         BUF_BYTES = 128;
  localparam int         TXQ_DEPTH = 4;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SCLK_MIN_NS       = 60;
  localparam int SCLK_HALF_MIN_CYC = (SCLK_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // both ends add two sync flops, so a half period must outlast the round trip
  localparam int SYNC_HALF_MIN_CYC = 6;
  localparam int SCLK_HALF_CYC     = 8;
  localparam int DC_PERIOD_CYC     = 1000;
  localparam int DC_B_OFS_CYC      = 500;
endpackage

// ### mhss_properties.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// wire checks between the two ends
// --------------------------------------------------------------
module mhss_properties (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic miso_oe
);
  logic [11:0] edges_ff;
  logic        sclk_ff;

  // edges counted one cycle late, still well before select rises
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      edges_ff <= 12'h000;
      sclk_ff  <= 1'h0;
    end else begin
      sclk_ff  <= sclk;
      edges_ff <= ss_n ? 12'h000 : edges_ff + 12'(sclk != sclk_ff);
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_reset_idle_pins: assert property (disable iff (1'h0) i_rst |-> ss_n && !miso_oe)
    else $error("pins not idle in reset");
  a_select_drives_miso: assert property ($fell(ss_n) |-> ##[1:4] miso_oe)
    else $error("miso not driven after select");
  a_deselect_frees: assert property ($rose(ss_n) |-> ##[1:4] !miso_oe)
    else $error("miso kept after deselect");
  a_idle_no_drive: assert property (ss_n [*4] |-> !miso_oe)
    else $error("miso driven while idle");
  // idle level moves to the mode's polarity on the first edge after reset
  a_clock_in_frame: assert property (
    !$past(i_rst) && !$past(i_rst, 2) && $changed(sclk) |-> !ss_n)
    else $error("clock moved outside frame");
  a_whole_bytes: assert property ($rose(ss_n) |-> edges_ff[3:0] == 4'h0 && edges_ff != 12'h000)
    else $error("frame not whole bytes");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*5])
    else $error("clock half period too short");
  a_frame_min_len: assert property ($fell(ss_n) |=> !ss_n [*8])
    else $error("select pulse too short");

  c_frame_end: cover property ($rose(ss_n));
  c_miso_on: cover property ($rose(miso_oe));
  c_shift: cover property (!ss_n && $changed(sclk));
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  logic       i_clk_sys = 1'h0;
  // raised at time zero so the asynchronous reset sees an edge before the first clock
  logic       i_rst     = 1'h0;
  logic       cpol      = 1'h0;
  logic       cpha      = 1'h0;
  logic [7:0] h_txd     = 8'h00;
  logic       h_txv     = 1'h0;
  logic       h_txr;
  logic [7:0] h_rxd;
  logic       h_rxv;
  logic [7:0] d_txd     = 8'h00;
  logic       d_txv     = 1'h0;
  logic       d_txr;
  logic [7:0] d_rxd;
  logic       d_rxv;
  logic       d_rxr     = 1'h0;
  logic       d_ovr;
  logic       d_sel;
  logic       dc_en     = 1'h0;
  logic       pa;
  logic       pb;
  int         mismatches   = 0;
  int         total_checks = 0;
  int         n_ovr = 0;
  int         n_pa  = 0;
  int         n_pb  = 0;
  int         lat;
  int         k;
  localparam logic [11:0] LAT = 12'(17 * mhss_pkg::SCLK_HALF_CYC + 1);

  initial forever #5 i_clk_sys = ~i_clk_sys;

  mhss_if mhss_if_inst ();
  mhss_hst mhss_hst_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cpol(cpol), .i_cpha(cpha),
    .i_tx_data(h_txd), .i_tx_valid(h_txv), .o_tx_ready(h_txr), .o_rx_data(h_rxd),
    .o_rx_valid(h_rxv), .ifc(mhss_if_inst.hst));
  // short distributed-clock period keeps the pulse count test brief
  mhss_dev #(.DC_PERIOD(8), .DC_B_OFS(4)) mhss_dev_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cpol(cpol), .i_cpha(cpha), .i_tx_data(d_txd), .i_tx_valid(d_txv), .o_tx_ready(d_txr),
    .o_rx_data(d_rxd), .o_rx_valid(d_rxv), .i_rx_ready(d_rxr), .o_rx_overrun(d_ovr),
    .o_selected(d_sel), .i_dc_enable(dc_en), .o_dist_clock_pulse_a(pa),
    .o_dist_clock_pulse_b(pb), .ifc(mhss_if_inst.dev));
  mhss_properties mhss_properties_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .sclk(mhss_if_inst.sclk), .ss_n(mhss_if_inst.ss_n), .miso_oe(mhss_if_inst.miso_oe));

  always @(negedge i_clk_sys) begin
    n_ovr += int'(d_ovr === 1'h1);
    n_pa  += int'(pa === 1'h1);
    n_pb  += int'(pb === 1'h1);
  end

  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic p, input logic h);
    i_rst <= 1'h1;
    cpol  <= p;
    cpha  <= h;
    repeat (20) @(posedge i_clk_sys);
    chk({h_txr, h_rxv, d_txr, d_rxv, d_sel, d_ovr, pa, pb}, 12'h000);
    i_rst <= 1'h0;
    n_ovr = 0;
    repeat (2) @(posedge i_clk_sys);
  endtask

  // host sends d and must get e back from the device
  task automatic xfer(input logic [7:0] d, input logic [7:0] e);
    lat = 0;
    @(negedge i_clk_sys);
    while (h_txr !== 1'h1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    h_txv <= 1'h1;
    h_txd <= d;
    @(posedge i_clk_sys);
    h_txv <= 1'h0;
    while (h_rxv !== 1'h1 && lat < 400) begin
      @(negedge i_clk_sys);
      lat++;
    end
    chk(h_rxd, e);
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge i_clk_sys);
    while (d_txr !== 1'h1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    d_txv <= 1'h1;
    d_txd <= d;
    @(posedge i_clk_sys);
    d_txv <= 1'h0;
  endtask

  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    while (d_rxv !== 1'h1 && n < 400) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(d_rxd, e);
    @(posedge i_clk_sys);
    d_rxr <= 1'h1;
    @(posedge i_clk_sys);
    d_rxr <= 1'h0;
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      push(8'h1D ^ 8'(m));
      xfer(8'h6A + 8'(m), 8'h1D ^ 8'(m));
      chk(12'(lat), LAT);
      pop(8'h6A + 8'(m));
      xfer(8'hC1, mhss_pkg::FILL_BYTE);
      pop(8'hC1);
    end
    $display("test modes done");
    do_reset(1'h0, 1'h0);
    for (int i = 0; i < 4; i++) push(8'h10 + 8'(i));
    repeat (2) @(negedge i_clk_sys);
    chk(d_txr, 12'h000);
    for (int i = 0; i < 5; i++) xfer(8'h50 + 8'(i), (i < 4) ? 8'h10 + 8'(i) : 8'h00);
    chk(d_txr, 12'h001);
    for (int i = 0; i < 5; i++) pop(8'h50 + 8'(i));
    repeat (3) @(negedge i_clk_sys);
    chk(d_rxv, 12'h000);
    $display("test queue done");
    do_reset(1'h0, 1'h0);
    for (int i = 0; i < 130; i++) begin
      xfer(8'(i), mhss_pkg::FILL_BYTE);
      if (i == 127) chk(12'(n_ovr), 12'h000);
    end
    repeat (12) @(negedge i_clk_sys);
    k = 0;
    // valid looked at off the edge, so the byte just taken is not seen twice
    @(negedge i_clk_sys);
    while (d_rxv === 1'h1 && k < 200) begin
      pop(8'(k));
      k++;
      @(negedge i_clk_sys);
    end
    chk(12'(k + n_ovr), 12'h082);
    chk(12'(k >= 128), 12'h001);
    $display("test buffer done");
    do_reset(1'h0, 1'h0);
    @(posedge i_clk_sys);
    h_txv <= 1'h1;
    h_txd <= 8'h2B;
    @(posedge i_clk_sys);
    h_txv <= 1'h0;
    push(8'h77);
    repeat (40) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(d_sel, 12'h001);
    // abort mid-frame: queue, buffer and host must all start clean
    do_reset(1'h0, 1'h0);
    chk(d_rxv, 12'h000);
    xfer(8'h2E, mhss_pkg::FILL_BYTE);
    chk(12'(lat), LAT);
    $display("test abort done");
    repeat (80) @(posedge i_clk_sys);
    chk(12'(n_pa + n_pb), 12'h000);
    dc_en <= 1'h1;
    repeat (2) @(posedge i_clk_sys);
    n_pa = 0;
    n_pb = 0;
    repeat (80) @(posedge i_clk_sys);
    chk({n_pa[5:0], n_pb[5:0]}, {6'h0A, 6'h0A});
    $display("test sync pulses done");
    tally_and_finish();
  end

  // whole run is about 21k cycles; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    mismatches++;
    tally_and_finish();
  end
endmodule
